/* File: core/tstb_tap.sv */
// Test access port of a boundary-scan transceiver: controller, instruction
// register, bypass and a sampled data register, with status for the core.
// Assumes the test controller drives TCK, TMS and TDI; TDO wire built outside.
// Notes on behaviour
// - All test logic except the core status crossing runs on TCK only
// - TDI, TMS, function inputs sampled TCK rising
// - TDO and function outputs change TCK falling
// - Capture-IR loads instruction register with 10000001
// - TDO driven from falling edge in shift
// - First bit taken on first rising edge in shift
// - One IR bit per rising edge, last exiting
// - All-ones instruction selects one-bit bypass path
// - TDO high-impedance from falling edge in Exit1
// - Active instruction updated falling edge in Update-IR
// - Bypass captures zero leaving Capture-DR
// - Update-DR transfers shifted data to output stage
`timescale 1ns/100ps
`default_nettype none
`include "tstb_regs.svh"

module tstb_tap
    import tstb_pkg::*;
#(
    parameter int NF_W = 18
)
(
    // Core clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Test access port
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // Normal-function pins seen by the data register
    input wire logic [NF_W-1:0] i_nf_in,
    output logic [NF_W-1:0] o_nf_out,
    // Core-side status
    output tstb_status_type o_core_status,
    output tstb_ir_type o_core_instr,
    output logic o_core_instr_upd
);

    // =================================================================
    // Elaboration checks
    generate
        if (NF_W < 2)
        begin : g_bad_width
            $error("tstb_tap: NF_W must be at least 2");
        end
    endgenerate

    // =================================================================
    // Decoders
    function automatic logic is_bypass(input tstb_ir_type ir);
        is_bypass = (ir == `TSTB_IR_BYPASS);
    endfunction

    function automatic logic is_shift(input tstb_state_type st);
        is_shift = (st == TSTB_SHIFT_IR) || (st == TSTB_SHIFT_DR);
    endfunction

    // =================================================================
    // Rising-edge state of the TCK domain
    tstb_state_type state_q, state_d;
    tstb_ir_type ir_sh_q, ir_sh_d;
    logic byp_q, byp_d;
    logic [NF_W-1:0] nf_sh_q, nf_sh_d;
    logic [2:0] tms_cnt_q, tms_cnt_d;
    // Falling-edge state of the TCK domain
    tstb_ir_type act_ir_q, act_ir_d;
    logic tdo_q, tdo_d;
    logic tdo_oe_q, tdo_oe_d;
    logic [NF_W-1:0] nf_out_q, nf_out_d;
    logic tlr_q, tlr_d;
    logic upd_tgl_q, upd_tgl_d;
    logic bypass_sel;

    assign bypass_sel = is_bypass(act_ir_q);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TSTB_TLR: state_d = i_tms ? TSTB_TLR : TSTB_RTI;
            TSTB_RTI: state_d = i_tms ? TSTB_SEL_DR : TSTB_RTI;
            TSTB_SEL_DR: state_d = i_tms ? TSTB_SEL_IR : TSTB_CAP_DR;
            TSTB_CAP_DR: state_d = i_tms ? TSTB_EXIT1_DR : TSTB_SHIFT_DR;
            TSTB_SHIFT_DR: state_d = i_tms ? TSTB_EXIT1_DR : TSTB_SHIFT_DR;
            TSTB_EXIT1_DR: state_d = i_tms ? TSTB_UPD_DR : TSTB_PAUSE_DR;
            TSTB_PAUSE_DR: state_d = i_tms ? TSTB_EXIT2_DR : TSTB_PAUSE_DR;
            TSTB_EXIT2_DR: state_d = i_tms ? TSTB_UPD_DR : TSTB_SHIFT_DR;
            TSTB_UPD_DR: state_d = i_tms ? TSTB_SEL_DR : TSTB_RTI;
            TSTB_SEL_IR: state_d = i_tms ? TSTB_TLR : TSTB_CAP_IR;
            TSTB_CAP_IR: state_d = i_tms ? TSTB_EXIT1_IR : TSTB_SHIFT_IR;
            TSTB_SHIFT_IR: state_d = i_tms ? TSTB_EXIT1_IR : TSTB_SHIFT_IR;
            TSTB_EXIT1_IR: state_d = i_tms ? TSTB_UPD_IR : TSTB_PAUSE_IR;
            TSTB_PAUSE_IR: state_d = i_tms ? TSTB_EXIT2_IR : TSTB_PAUSE_IR;
            TSTB_EXIT2_IR: state_d = i_tms ? TSTB_UPD_IR : TSTB_SHIFT_IR;
            TSTB_UPD_IR: state_d = i_tms ? TSTB_SEL_DR : TSTB_RTI;
            default: state_d = TSTB_TLR;
        endcase
    end

    always_comb
    begin
        ir_sh_d = ir_sh_q;
        byp_d = byp_q;
        nf_sh_d = nf_sh_q;
        case (state_q)
            TSTB_CAP_IR: ir_sh_d = `TSTB_IR_CAPTURE;
            // Shift includes the edge that leaves the state
            TSTB_SHIFT_IR: ir_sh_d = {i_tdi, ir_sh_q[`TSTB_IR_W-1:1]};
            TSTB_CAP_DR:
            begin
                byp_d = bypass_sel ? 1'b0 : byp_q;
                nf_sh_d = bypass_sel ? nf_sh_q : i_nf_in;
            end
            TSTB_SHIFT_DR:
            begin
                byp_d = bypass_sel ? i_tdi : byp_q;
                nf_sh_d = bypass_sel ? nf_sh_q : {i_tdi, nf_sh_q[NF_W-1:1]};
            end
            default: ir_sh_d = ir_sh_q;
        endcase
        // Counts consecutive TMS highs, saturating; checked only
        if (i_tms)
        begin
            tms_cnt_d = (tms_cnt_q == `TSTB_TMS_RESET_EDGES) ? tms_cnt_q : tms_cnt_q + 3'h1;
        end
        else
        begin
            tms_cnt_d = 3'h0;
        end
    end

    always_ff @(posedge i_tck or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q <= TSTB_TLR;
            ir_sh_q <= `TSTB_IR_CAPTURE;
            byp_q <= 1'b0;
            nf_sh_q <= '0;
            tms_cnt_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            ir_sh_q <= ir_sh_d;
            byp_q <= byp_d;
            nf_sh_q <= nf_sh_d;
            tms_cnt_q <= tms_cnt_d;
        end
    end

    // =================================================================
    // Falling-edge outputs
    always_comb
    begin
        act_ir_d = act_ir_q;
        nf_out_d = nf_out_q;
        upd_tgl_d = upd_tgl_q;
        tdo_d = tdo_q;
        tdo_oe_d = is_shift(state_q);
        tlr_d = (state_q == TSTB_TLR);
        if (state_q == TSTB_SHIFT_IR)
        begin
            tdo_d = ir_sh_q[0];
        end
        else if (state_q == TSTB_SHIFT_DR)
        begin
            tdo_d = bypass_sel ? byp_q : nf_sh_q[0];
        end
        if (state_q == TSTB_TLR)
        begin
            act_ir_d = `TSTB_IR_RESET;
        end
        else if (state_q == TSTB_UPD_IR)
        begin
            act_ir_d = ir_sh_q;
            upd_tgl_d = ~upd_tgl_q;
        end
        if ((state_q == TSTB_UPD_DR) && !bypass_sel)
        begin
            nf_out_d = nf_sh_q;
        end
    end

    always_ff @(negedge i_tck or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            act_ir_q <= `TSTB_IR_RESET;
            tdo_q <= `TSTB_TDO_RESET;
            tdo_oe_q <= 1'b0;
            nf_out_q <= '0;
            tlr_q <= 1'b1;
            upd_tgl_q <= 1'b0;
        end
        else
        begin
            act_ir_q <= act_ir_d;
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
            nf_out_q <= nf_out_d;
            tlr_q <= tlr_d;
            upd_tgl_q <= upd_tgl_d;
        end
    end

    assign o_tdo = tdo_q;
    assign o_tdo_oe = tdo_oe_q;
    assign o_nf_out = nf_out_q;

    // =================================================================
    // Crossing into the core clock domain
    // Instruction word is stable for many TCK cycles after its toggle,
    // so sampling it on the synchronised toggle edge is safe.
    logic [`TSTB_SYNC_STAGES-1:0] byp_sync_q, tlr_sync_q, tgl_sync_q;
    logic tgl_seen_q, tgl_seen_d;
    tstb_status_type status_q, status_d;
    tstb_ir_type instr_q, instr_d;
    logic upd_q, upd_d;

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            // Match the TCK-side reset levels so status does not dip after reset
            byp_sync_q <= '1;
            tlr_sync_q <= '1;
            tgl_sync_q <= '0;
        end
        else
        begin
            byp_sync_q <= {byp_sync_q[0], bypass_sel};
            tlr_sync_q <= {tlr_sync_q[0], tlr_q};
            tgl_sync_q <= {tgl_sync_q[0], upd_tgl_q};
        end
    end

    always_comb
    begin
        tgl_seen_d = tgl_sync_q[1];
        status_d.bypass = byp_sync_q[1];
        status_d.test_reset = tlr_sync_q[1];
        upd_d = (tgl_sync_q[1] != tgl_seen_q);
        instr_d = upd_d ? act_ir_q : instr_q;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tgl_seen_q <= 1'b0;
            status_q <= '{bypass: 1'b1, test_reset: 1'b1};
            instr_q <= `TSTB_IR_RESET;
            upd_q <= 1'b0;
        end
        else
        begin
            tgl_seen_q <= tgl_seen_d;
            status_q <= status_d;
            instr_q <= instr_d;
            upd_q <= upd_d;
        end
    end

    assign o_core_status = status_q;
    assign o_core_instr = instr_q;
    assign o_core_instr_upd = upd_q;

    // =================================================================
    // Assertions
    a_ir_capture_val: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_CAP_IR) |=> (ir_sh_q == 8'h81))
        else $error("instruction capture value wrong");

    a_ir_shift_in: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_SHIFT_IR) |=> (ir_sh_q[7] == $past(i_tdi))
            && (ir_sh_q[6:0] == $past(ir_sh_q[7:1])))
        else $error("instruction shift wrong");

    a_tdo_enable_win: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        o_tdo_oe == is_shift(state_q))
        else $error("TDO enable outside shift window");

    a_tdo_off_exit: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        is_shift(state_q) && i_tms |=> !o_tdo_oe)
        else $error("TDO still driven after Exit1");

    a_bypass_delay: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_SHIFT_DR) && bypass_sel ##1 (state_q == TSTB_SHIFT_DR)
            |-> (o_tdo == $past(i_tdi)))
        else $error("bypass data not one cycle late");

    a_bypass_zero: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_CAP_DR) && bypass_sel |=> !byp_q && (!is_shift(state_q) || !o_tdo))
        else $error("bypass did not capture zero");

    a_bypass_isolates: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_SHIFT_DR) && (act_ir_q == 8'hFF) |=> $stable(nf_sh_q))
        else $error("data register moved under bypass");

    a_ir_update_fall: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_UPD_IR) |=> (act_ir_q == $past(ir_sh_q)))
        else $error("active instruction not updated");

    a_dr_update_out: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (state_q == TSTB_UPD_DR) && !bypass_sel |=> (o_nf_out == $past(nf_sh_q)))
        else $error("output stage not updated");

    a_five_tms_reset: assert property (
        @(posedge i_tck) disable iff (!i_nrst)
        (tms_cnt_q == 3'h5) |-> (state_q == TSTB_TLR))
        else $error("five TMS highs did not reset");

endmodule

`default_nettype wire

/* File: core/tstb_regs.svh */
// Constants of the scan test access port: instruction codes and reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TSTB_REGS_SVH
`define TSTB_REGS_SVH

// =====================================================================
// Instruction register
`define TSTB_IR_W 8
`define TSTB_IR_CAPTURE 8'h81
`define TSTB_IR_BYPASS 8'hFF
`define TSTB_IR_RESET 8'hFF

// =====================================================================
// Reset values and helper counts
`define TSTB_TDO_RESET 1'b0
`define TSTB_TMS_RESET_EDGES 3'h5
`define TSTB_SYNC_STAGES 2

`endif

/* File: core/tstb_pkg.sv */
// Types shared by the scan test access port logic.
// Assumes the constants header sits beside it in core/.
`include "tstb_regs.svh"

package tstb_pkg;

    // =================================================================
    // Controller states
    typedef enum logic [3:0]
    {
        TSTB_TLR, TSTB_RTI, TSTB_SEL_DR, TSTB_CAP_DR, TSTB_SHIFT_DR,
        TSTB_EXIT1_DR, TSTB_PAUSE_DR, TSTB_EXIT2_DR, TSTB_UPD_DR,
        TSTB_SEL_IR, TSTB_CAP_IR, TSTB_SHIFT_IR, TSTB_EXIT1_IR,
        TSTB_PAUSE_IR, TSTB_EXIT2_IR, TSTB_UPD_IR
    } tstb_state_type;

    // =================================================================
    // Status seen by the core clock domain
    typedef struct packed
    {
        logic bypass;
        logic test_reset;
    } tstb_status_type;

    typedef logic [`TSTB_IR_W-1:0] tstb_ir_type;

endpackage

/* File: testbench/tstb_ctrl_model.sv */
// Board test controller model: owns TCK, TMS and TDI, resolves TDO.
// Assumes the bench calls step once per TCK cycle; TCK idles low between.
`timescale 1ns/100ps
`default_nettype none

module tstb_ctrl_model
(
    // Test access port towards the device
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo,
    input wire logic i_tdo_oe
);
    wire logic tdo_line;

    // No pull on the board, so a released TDO floats
    assign tdo_line = i_tdo_oe ? i_tdo : 1'bz;

    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end

    // One TCK cycle of 48 ns; TMS moves just after the falling edge
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        #1;
        o_tms = tms;
        o_tdi = tdi;
        #23;
        tdo = tdo_line;
        oe = i_tdo_oe;
        o_tck = 1'b1;
        #24;
        o_tck = 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: testbench/tstb_tap_tb.sv */
// Bench for the scan test access port: queue model predicts TDO and updates.
// Assumes the controller model owns the link; core clock runs at 200 MHz.
`timescale 1ns/100ps
`default_nettype none

module tstb_tap_tb;
    import tstb_pkg::*;

    localparam int NF_W = 18;
    logic clk;
    logic nrst;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [NF_W-1:0] nf_in;
    logic [NF_W-1:0] nf_out;
    logic [NF_W-1:0] nf_keep;
    tstb_status_type status;
    tstb_ir_type instr;
    logic instr_upd;
    int error_cnt;
    int tests_run;
    int upd_cnt;
    logic [31:0] din;
    logic [7:0] op;
    logic o;
    logic e;

    tstb_tap #(.NF_W(NF_W)) dut (
        .i_core_clk(clk), .i_nrst(nrst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_nf_in(nf_in), .o_nf_out(nf_out),
        .o_core_status(status), .o_core_instr(instr), .o_core_instr_upd(instr_upd)
    );

    tstb_ctrl_model ctrl (
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo), .i_tdo_oe(tdo_oe)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
        if (instr_upd === 1'b1)
            upd_cnt++;

    task automatic print_verdict();
        $display("mismatches=%0d comparisons=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // From idle: scan n bits of d; the register of len bits first gives cap
    task automatic scan(input bit ir, input int n, input logic [31:0] d,
                        input logic [31:0] cap, input int len);
        int q[$];
        for (int i = 0; i < len; i++)
            q.push_back(cap[i]);
        ctrl.step(1'b1, 1'b0, o, e);
        if (ir)
            ctrl.step(1'b1, 1'b0, o, e);
        ctrl.step(1'b0, 1'b1, o, e);
        ctrl.step(1'b0, 1'b1, o, e);
        for (int i = 0; i < n; i++)
        begin
            ctrl.step(i == n - 1, d[i], o, e);
            q.push_back(d[i]);
            chk(e, 1'b1);
            chk(o, q.pop_front());
        end
        ctrl.step(1'b1, 1'b1, o, e);
        chk(e, 1'b0);
        ctrl.step(1'b0, 1'b0, o, e);
    endtask

    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        upd_cnt = 0;
        nf_in = '0;
        nrst = 1'b0;
        void'($urandom(32'h47c9_348e));
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        chk(tdo_oe, 1'b0);
        chk(instr, 8'hff);
        chk(status, 2'b11);
        chk(nf_out, 18'h0_0000);
        ctrl.step(1'b0, 1'b0, o, e);
        // Status crosses two synchroniser stages and one register
        repeat (4) @(posedge clk);
        #1;
        chk(status.test_reset, 1'b0);
        // Any code except all ones selects the sampled data register
        op = 8'($urandom());
        if (op == 8'hff)
            op = 8'h5a;
        scan(1'b1, 8, {24'h00_0000, op}, 8'h81, 8);
        chk(upd_cnt, 1);
        chk(instr, op);
        chk(status.bypass, 1'b0);
        @(posedge clk);
        #1 nf_in = NF_W'($urandom());
        din = $urandom();
        scan(1'b0, NF_W, din, {14'h0000, nf_in}, NF_W);
        chk(nf_out, din[NF_W-1:0]);
        nf_keep = nf_out;
        scan(1'b1, 8, 32'h0000_00ff, 8'h81, 8);
        chk(upd_cnt, 2);
        chk(instr, 8'hff);
        chk(status.bypass, 1'b1);
        din = $urandom();
        scan(1'b0, 6, din, 32'h0, 1);
        chk(nf_out, nf_keep);
        // Through Pause-DR: link released, captured zero kept
        ctrl.step(1'b1, 1'b0, o, e);
        ctrl.step(1'b0, 1'b0, o, e);
        ctrl.step(1'b1, 1'b0, o, e);
        ctrl.step(1'b0, 1'b0, o, e);
        ctrl.step(1'b0, 1'b0, o, e);
        chk(e, 1'b0);
        ctrl.step(1'b1, 1'b0, o, e);
        ctrl.step(1'b0, 1'b0, o, e);
        ctrl.step(1'b1, 1'b1, o, e);
        chk(e, 1'b1);
        chk(o, 1'b0);
        ctrl.step(1'b1, 1'b0, o, e);
        ctrl.step(1'b0, 1'b0, o, e);
        chk(nf_out, nf_keep);
        // Abort from Select-DR: five highs must land in reset
        ctrl.step(1'b1, 1'b0, o, e);
        repeat (5) ctrl.step(1'b1, 1'b0, o, e);
        chk(status.test_reset, 1'b1);
        chk(tdo_oe, 1'b0);
        print_verdict();
    end
endmodule

`default_nettype wire
